// ---- src/srtc_pkg.sv ----
// shared constants and types for the split reload timer control block
package srtc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h91;
  localparam logic [7:0] IDX_RLL = 8'h92;
  localparam logic [7:0] IDX_RLH = 8'h93;
  localparam logic [7:0] IDX_CNTL = 8'h94;
  localparam logic [7:0] IDX_CNTH = 8'h95;
  localparam logic [7:0] IDX_CLKSEL = 8'h96;
  localparam logic [7:0] IDX_IRQST = 8'h97;
  localparam logic [7:0] IDX_IRQMSK = 8'h98;
  localparam logic [7:0] IDX_NONE = 8'h00;
  // timer3_control fields
  localparam int B_HI_FLAG = 7;
  localparam int B_LO_FLAG = 6;
  localparam int B_LO_IRQ_EN = 5;
  localparam int B_CAP_EN = 4;
  localparam int B_SPLIT = 3;
  localparam int B_RUN = 2;
  localparam int B_XSEL = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // clock_select_control fields
  localparam int CKS_LOW = 0;
  localparam int CKS_HIGH = 1;
  // interrupt status and mask fields
  localparam int IRQ_HI = 0;
  localparam int IRQ_LO = 1;
  localparam int IRQ_CAP = 2;
  // external clock select encodings
  localparam logic [1:0] XSEL_SYS12 = 2'h0;
  localparam logic [1:0] XSEL_EXT8 = 2'h1;
  localparam logic [1:0] XSEL_RSVD = 2'h2;
  localparam logic [1:0] XSEL_LFO8 = 2'h3;
  // divider terminal counts
  localparam logic [3:0] SYS_DIV_LAST = 4'hB;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } srtc_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } srtc_ahb_rsp_t;

  typedef struct packed {
    logic src_tick;
    logic lfo_fall;
  } srtc_tick_t;

  typedef struct packed {
    logic ext_s1, ext_s2, ext_s3, ext_s4;
    logic lfo_s1, lfo_s2, lfo_s3, lfo_s4;
    logic sus_s1, sus_s2;
    logic [2:0] ext_div;
    logic [2:0] lfo_div;
    logic [3:0] sys_div;
  } srtc_clk_state_t;

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_idx;
    logic rd_done;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] rll;
    logic [7:0] rlh;
    logic [7:0] cnt_l;
    logic [7:0] cnt_h;
    logic [1:0] fast_sel;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
  } srtc_state_t;
endpackage : srtc_pkg

// ---- src/srtc_clk_src.sv ----
// clock source selection, division and resynchronisation for the timer
`timescale 1ns/10ps
`default_nettype none
module srtc_clk_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous pins
  input wire logic ext_osc_i,
  input wire logic lfo_i,
  input wire logic suspend_i,
  // selection and ticks
  input wire logic [1:0] ext_sel_i,
  output srtc_pkg::srtc_tick_t tick_o
);
  import srtc_pkg::*;

  srtc_clk_state_t s_q, s_d;
  logic ext_rise;
  logic lfo_rise;

  always_comb begin
    s_d = s_q;
    s_d.ext_s1 = ext_osc_i;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    s_d.ext_s4 = s_q.ext_s3;
    s_d.lfo_s1 = lfo_i;
    s_d.lfo_s2 = s_q.lfo_s1;
    s_d.lfo_s3 = s_q.lfo_s2;
    s_d.lfo_s4 = s_q.lfo_s3;
    s_d.sus_s1 = suspend_i;
    s_d.sus_s2 = s_q.sus_s1;
    // suspend skips the retiming stage, one cycle earlier
    if (s_q.sus_s2) begin
      ext_rise = s_q.ext_s2 & ~s_q.ext_s3;
      lfo_rise = s_q.lfo_s2 & ~s_q.lfo_s3;
    end else begin
      ext_rise = s_q.ext_s3 & ~s_q.ext_s4;
      lfo_rise = s_q.lfo_s3 & ~s_q.lfo_s4;
    end
    if (ext_rise) begin
      s_d.ext_div = 3'(s_q.ext_div + 3'h1);
    end
    if (lfo_rise) begin
      s_d.lfo_div = 3'(s_q.lfo_div + 3'h1);
    end
    if (s_q.sys_div == SYS_DIV_LAST) begin
      s_d.sys_div = 4'h0;
    end else begin
      s_d.sys_div = 4'(s_q.sys_div + 4'h1);
    end
    tick_o.lfo_fall = ~s_q.lfo_s3 & s_q.lfo_s4;
    case (ext_sel_i)
      XSEL_SYS12: tick_o.src_tick = (s_q.sys_div == SYS_DIV_LAST);
      XSEL_EXT8: tick_o.src_tick = ext_rise & (s_q.ext_div == OSC_DIV_LAST);
      XSEL_LFO8: tick_o.src_tick = lfo_rise & (s_q.lfo_div == OSC_DIV_LAST);
      default: tick_o.src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : srtc_clk_src
`default_nettype wire

// ---- src/srtc_timer.sv ----
// split reload timer: control register, counters, capture and bus slave
//
// What this block does
// - the high overflow flag sets whenever the upper byte rolls over from FF to its reload value.
// - in 16-bit mode the high flag sets only when all 16 bits wrap or on a capture.
// - a set high overflow with its interrupt enabled raises the interrupt.
// - the overflow flags are never cleared by hardware, only by software.
// - the low overflow flag sets on every low byte wrap, in any mode.
// - low byte overflows interrupt when the low enable and timer irq are on.
// - with capture on, an oscillator falling edge copies count to reload.
// - the split bit picks one 16-bit counter or two 8-bit counters.
// - the 16-bit counter and the split high byte run only while run control is one.
// - in split mode run gates only the high byte; low byte always counts.
// - the select field picks sysclk/12, external/8 or oscillator/8.
// - divided external sources are resynchronised except in suspend.
// - split bytes share one source, each may pick the plain sysclk.
// - a 16-bit wrap loads the counter from the 16-bit reload pair.
// - in split mode each byte reloads from its own reload byte.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module srtc_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire srtc_pkg::srtc_ahb_req_t ahb_i,
  input wire logic hready_i,
  output srtc_pkg::srtc_ahb_rsp_t ahb_o,
  // clock pins
  input wire logic ext_osc_i,
  input wire logic lfo_i,
  input wire logic suspend_i,
  // interrupt
  output logic irq_o
);
  import srtc_pkg::*;

  srtc_state_t s_q, s_d;
  srtc_tick_t tick;
  logic hready;
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic wr_ctrl, wr_rll, wr_rlh, wr_cntl, wr_cnth;
  logic wr_clk, wr_st, wr_msk;
  logic tick_lo, tick_hi;
  logic split, run;
  logic lo_evt, hi_evt, cap_evt;
  logic [7:0] rmux;

  srtc_clk_src u_clk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_osc_i(ext_osc_i),
    .lfo_i(lfo_i),
    .suspend_i(suspend_i),
    .ext_sel_i(s_q.ctrl[B_XSEL +: 2]),
    .tick_o(tick)
  );

  // reads take one wait state so a write just before is always seen
  assign hready = ~(s_q.dp_valid & ~s_q.dp_write & ~s_q.rd_done);
  assign acc = hready_i & ahb_i.hsel & ahb_i.htrans[1];
  assign wr = s_q.dp_valid & s_q.dp_write;
  assign wd = ahb_i.hwdata[7:0];
  assign wr_ctrl = wr & (s_q.dp_idx == IDX_CTRL);
  assign wr_rll = wr & (s_q.dp_idx == IDX_RLL);
  assign wr_rlh = wr & (s_q.dp_idx == IDX_RLH);
  assign wr_cntl = wr & (s_q.dp_idx == IDX_CNTL);
  assign wr_cnth = wr & (s_q.dp_idx == IDX_CNTH);
  assign wr_clk = wr & (s_q.dp_idx == IDX_CLKSEL);
  assign wr_st = wr & (s_q.dp_idx == IDX_IRQST);
  assign wr_msk = wr & (s_q.dp_idx == IDX_IRQMSK);
  assign split = s_q.ctrl[B_SPLIT];
  assign run = s_q.ctrl[B_RUN];
  // one shared source, each byte may bypass it with the raw sysclk
  assign tick_lo = s_q.fast_sel[CKS_LOW] | tick.src_tick;
  assign tick_hi = s_q.fast_sel[CKS_HIGH] | tick.src_tick;

  assign ahb_o.hrdata = s_q.rdata;
  assign ahb_o.hreadyout = hready;
  assign ahb_o.hresp = 1'b0;
  // low byte events only reach the pin with the low byte enable
  assign irq_o = |(s_q.irq_st & s_q.irq_msk &
                   {1'b1, s_q.ctrl[B_LO_IRQ_EN], 1'b1});

  always_comb begin
    case (s_q.dp_idx)
      IDX_CTRL: rmux = s_q.ctrl;
      IDX_RLL: rmux = s_q.rll;
      IDX_RLH: rmux = s_q.rlh;
      IDX_CNTL: rmux = s_q.cnt_l;
      IDX_CNTH: rmux = s_q.cnt_h;
      IDX_CLKSEL: rmux = {6'h00, s_q.fast_sel};
      IDX_IRQST: rmux = {5'h00, s_q.irq_st};
      IDX_IRQMSK: rmux = {5'h00, s_q.irq_msk};
      default: rmux = 8'h00;
    endcase
  end

  always_comb begin
    logic [15:0] cnt16;
    cnt16 = {s_q.cnt_h, s_q.cnt_l};
    s_d = s_q;
    lo_evt = 1'b0;
    hi_evt = 1'b0;
    cap_evt = 1'b0;
    // bus pipeline
    if (s_q.dp_valid & ~s_q.dp_write & ~s_q.rd_done) begin
      s_d.rdata = {24'h000000, rmux};
      s_d.rd_done = 1'b1;
    end
    if (hready) begin
      s_d.dp_valid = acc;
      s_d.dp_write = ahb_i.hwrite;
      s_d.dp_idx = (ahb_i.haddr[31:10] == 22'h000000) ?
                   ahb_i.haddr[9:2] : IDX_NONE;
      s_d.rd_done = 1'b0;
    end
    // counting
    if (!split) begin
      if (run & tick_lo) begin
        lo_evt = (s_q.cnt_l == BYTE_MAX);
        if (cnt16 == WORD_MAX) begin
          {s_d.cnt_h, s_d.cnt_l} = {s_q.rlh, s_q.rll};
          hi_evt = 1'b1;
        end else begin
          {s_d.cnt_h, s_d.cnt_l} = 16'(cnt16 + 16'h0001);
        end
      end
    end else begin
      if (tick_lo) begin
        if (s_q.cnt_l == BYTE_MAX) begin
          s_d.cnt_l = s_q.rll;
          lo_evt = 1'b1;
        end else begin
          s_d.cnt_l = 8'(s_q.cnt_l + 8'h01);
        end
      end
      if (run & tick_hi) begin
        if (s_q.cnt_h == BYTE_MAX) begin
          s_d.cnt_h = s_q.rlh;
          hi_evt = 1'b1;
        end else begin
          s_d.cnt_h = 8'(s_q.cnt_h + 8'h01);
        end
      end
    end
    // capture overwrites the reload pair with the running count
    if (s_q.ctrl[B_CAP_EN] & tick.lfo_fall) begin
      {s_d.rlh, s_d.rll} = cnt16;
      cap_evt = 1'b1;
    end
    // software writes win over counting on the count and reload bytes
    if (wr_rll) begin
      s_d.rll = wd;
    end
    if (wr_rlh) begin
      s_d.rlh = wd;
    end
    if (wr_cntl) begin
      s_d.cnt_l = wd;
    end
    if (wr_cnth) begin
      s_d.cnt_h = wd;
    end
    if (wr_clk) begin
      s_d.fast_sel = wd[1:0];
    end
    if (wr_msk) begin
      s_d.irq_msk = wd[2:0];
    end
    if (wr_ctrl) begin
      s_d.ctrl = wd;
    end
    // hardware sets win over a clearing write in the same cycle
    if (hi_evt | cap_evt) begin
      s_d.ctrl[B_HI_FLAG] = 1'b1;
    end
    if (lo_evt) begin
      s_d.ctrl[B_LO_FLAG] = 1'b1;
    end
    s_d.irq_st = (s_q.irq_st & ~(wr_st ? wd[2:0] : 3'h0)) |
                 {cap_evt, lo_evt, hi_evt};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_full_wrap: assert property (
    !split && run && tick_lo && {s_q.cnt_h, s_q.cnt_l} == 16'hFFFF &&
    !wr_cntl && !wr_cnth
    |=> s_q.ctrl[B_HI_FLAG] && s_q.cnt_l == $past(s_q.rll) &&
        s_q.cnt_h == $past(s_q.rlh))
    else $error("16-bit wrap did not reload and flag");

  chk_no_early_hi: assert property (
    !split && run && tick_lo && s_q.cnt_l == 8'hFF &&
    s_q.cnt_h != 8'hFF |-> !hi_evt)
    else $error("high flag event before full wrap");

  chk_low_flag: assert property (
    tick_lo && s_q.cnt_l == 8'hFF && (split || run)
    |=> s_q.ctrl[B_LO_FLAG] && s_q.irq_st[IRQ_LO])
    else $error("low byte wrap missed its flag");

  chk_flag_hold: assert property (
    s_q.ctrl[B_HI_FLAG] && s_q.ctrl[B_LO_FLAG] && !wr_ctrl
    |=> s_q.ctrl[B_HI_FLAG] && s_q.ctrl[B_LO_FLAG])
    else $error("overflow flag cleared by hardware");

  chk_split_low: assert property (
    split && !run && tick_lo && s_q.cnt_l != 8'hFF && !wr_cntl &&
    !wr_cnth
    |=> s_q.cnt_l == 8'($past(s_q.cnt_l) + 8'h01) && $stable(s_q.cnt_h))
    else $error("split low byte not free running");

  chk_stop_hold: assert property (
    (!split && !run && !wr_cntl && !wr_cnth) [*2]
    |-> $stable({s_q.cnt_h, s_q.cnt_l}))
    else $error("stopped counter moved");

  chk_cap_copy: assert property (
    s_q.ctrl[B_CAP_EN] && tick.lfo_fall && !wr_rll && !wr_rlh
    |=> {s_q.rlh, s_q.rll} == $past({s_q.cnt_h, s_q.cnt_l}) &&
        s_q.irq_st[IRQ_CAP])
    else $error("capture did not copy the count");

  chk_hi_irq: assert property (
    hi_evt && s_q.irq_msk[IRQ_HI] && !wr_msk ##1 !wr_st && !wr_msk
    |-> irq_o ##1 irq_o)
    else $error("high overflow did not interrupt");

  chk_lo_irq_gate: assert property (
    s_q.irq_st == (3'h1 << IRQ_LO) && !s_q.ctrl[B_LO_IRQ_EN] |-> !irq_o)
    else $error("low byte interrupt without its enable");

  chk_sw_set: assert property (
    wr_ctrl && wd[B_HI_FLAG] && wd[B_LO_FLAG]
    |=> s_q.ctrl[B_HI_FLAG] && s_q.ctrl[B_LO_FLAG])
    else $error("software flag set lost");

  chk_count_step: assert property (
    !split && run && tick_lo && {s_q.cnt_h, s_q.cnt_l} != 16'hFFFF &&
    !wr_cntl && !wr_cnth
    |=> {s_q.cnt_h, s_q.cnt_l} ==
        16'($past({s_q.cnt_h, s_q.cnt_l}) + 16'h0001))
    else $error("running counter did not step");

  chk_split_hi_wrap: assert property (
    split && run && tick_hi && s_q.cnt_h == 8'hFF && !wr_cnth
    |=> s_q.cnt_h == $past(s_q.rlh) && s_q.ctrl[B_HI_FLAG])
    else $error("split high byte did not reload");

  chk_split_lo_wrap: assert property (
    split && tick_lo && s_q.cnt_l == 8'hFF && !wr_cntl
    |=> s_q.cnt_l == $past(s_q.rll))
    else $error("split low byte did not reload");

  chk_split_hi_hold: assert property (
    split && !run && !wr_cnth |=> $stable(s_q.cnt_h))
    else $error("stopped split high byte moved");

  chk_hi_irq_level: assert property (
    s_q.irq_st[IRQ_HI] && s_q.irq_msk[IRQ_HI] |-> irq_o)
    else $error("pending high overflow without interrupt");

  chk_lo_irq_on: assert property (
    s_q.irq_st[IRQ_LO] && s_q.irq_msk[IRQ_LO] &&
    s_q.ctrl[B_LO_IRQ_EN] |-> irq_o)
    else $error("enabled low byte overflow without interrupt");

  chk_cap_irq_level: assert property (
    s_q.irq_st[IRQ_CAP] && s_q.irq_msk[IRQ_CAP] |-> irq_o)
    else $error("pending capture without interrupt");

  chk_cap_flag: assert property (
    s_q.ctrl[B_CAP_EN] && tick.lfo_fall |=> s_q.ctrl[B_HI_FLAG])
    else $error("capture did not set the high flag");

  chk_sw_clear: assert property (
    wr_ctrl && !wd[B_HI_FLAG] && !hi_evt && !cap_evt
    |=> !s_q.ctrl[B_HI_FLAG])
    else $error("software clear of high flag lost");

  chk_rsvd_sel: assert property (
    s_q.ctrl[B_XSEL +: 2] == XSEL_RSVD |-> !tick.src_tick)
    else $error("reserved source select produced a tick");

  chk_reload_write: assert property (
    wr_rll |=> s_q.rll == $past(wd))
    else $error("reload low byte write lost");

  chk_read_wait: assert property (
    acc && !ahb_i.hwrite |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
    else $error("read answer not after one wait state");
endmodule : srtc_timer
`default_nettype wire

// ---- verification/srtc_tb.sv ----
// self-checking testbench for the split reload timer control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import srtc_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } srtc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  srtc_ahb_req_t ahb_i = '0;
  srtc_ahb_rsp_t ahb_o;
  wire logic hready;
  logic ext_osc_i = 1'b0;
  logic lfo_i = 1'b0;
  logic suspend_i = 1'b0;
  logic irq_o;
  int err_count = 0;
  int checked = 0;
  logic [7:0] rd;
  srtc_row_t rows [8] = '{
    '{IDX_RLL, 8'h5A, 8'h5A}, '{IDX_RLH, 8'hA5, 8'hA5},
    '{IDX_CNTL, 8'h12, 8'h12}, '{IDX_CNTH, 8'h34, 8'h34},
    '{IDX_CLKSEL, 8'h03, 8'h03}, '{IDX_IRQMSK, 8'h07, 8'h07},
    '{IDX_CTRL, 8'hC3, 8'hC3}, '{8'h90, 8'hFF, 8'h00}};
  logic [1:0] xs [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
  logic [7:0] ex [4] = '{8'h02, 8'h02, 8'h00, 8'h02};

  // one slave, so its hreadyout is the bus hready
  assign hready = ahb_o.hreadyout;

  always #10 clk_i = ~clk_i;

  srtc_timer i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ahb_i(ahb_i),
    .hready_i(hready),
    .ahb_o(ahb_o),
    .ext_osc_i(ext_osc_i),
    .lfo_i(lfo_i),
    .suspend_i(suspend_i),
    .irq_o(irq_o)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // called just after a rising edge; waits are bounded, not assumed
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rdo);
    int n;
    n = 0;
    ahb_i.hsel <= 1'b1;
    ahb_i.htrans <= 2'h2;
    ahb_i.hwrite <= wr;
    ahb_i.hsize <= 3'h2;
    ahb_i.haddr <= {22'h0, idx, 2'h0};
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    ahb_i.htrans <= 2'h0;
    ahb_i.hwdata <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rdo = ahb_o.hrdata[7:0];
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] idx,
                       input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    check(what, rd, exp);
  endtask : rdchk

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      end_of_test();
    end
  endtask : wait_irq

  // both pins together; 16 pulses keep both dividers in phase
  task automatic pulses(input int cnt);
    repeat (cnt) begin
      ext_osc_i <= 1'b1;
      lfo_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_osc_i <= 1'b0;
      lfo_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulses

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check("irq after reset", {7'h0, irq_o}, 8'h00);
    for (int i = 8'h91; i <= 8'h98; i++) begin
      rdchk("reset value", i[7:0], 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdchk("register row", rows[i].idx, rows[i].exp);
    end
    wr(IDX_CTRL, 8'h00);
    wr(IDX_IRQMSK, 8'h00);
    $display("test registers done");
    // 16-bit: first low wrap at FEFF, full wrap at FFFF
    wr(IDX_CLKSEL, 8'h01);
    wr(IDX_RLL, 8'h10);
    wr(IDX_RLH, 8'h20);
    wr(IDX_CNTL, 8'hF0);
    wr(IDX_CNTH, 8'hFE);
    wr(IDX_IRQMSK, 8'h02);
    wr(IDX_CTRL, 8'h24);
    wait_irq(400);
    rdchk("ctrl low wrap", IDX_CTRL, 8'h64);
    wr(IDX_IRQST, 8'h02);
    wr(IDX_IRQMSK, 8'h01);
    wait_irq(400);
    rdchk("ctrl full wrap", IDX_CTRL, 8'hE4);
    rdchk("reloaded high", IDX_CNTH, 8'h20);
    rdchk("status", IDX_IRQST, 8'h03);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_IRQST, 8'h07);
    @(posedge clk_i);
    check("irq cleared", {7'h0, irq_o}, 8'h00);
    $display("test sixteen bit done");
    // split with run off: low keeps counting, high holds
    wr(IDX_CLKSEL, 8'h03);
    wr(IDX_RLL, 8'hF0);
    wr(IDX_CNTL, 8'hFE);
    wr(IDX_CNTH, 8'h77);
    wr(IDX_IRQMSK, 8'h07);
    wr(IDX_CTRL, 8'h08);
    repeat (20) @(posedge clk_i);
    rdchk("split high held", IDX_CNTH, 8'h77);
    bus(1'b0, IDX_CNTL, 8'h00, rd);
    check("split low reload", {4'h0, rd[7:4]}, 8'h0F);
    rdchk("split ctrl", IDX_CTRL, 8'h48);
    check("split low irq gated", {7'h0, irq_o}, 8'h00);
    // split with run on: high byte wraps from FD in three ticks
    wr(IDX_CNTH, 8'hFD);
    wr(IDX_CTRL, 8'h0C);
    repeat (4) @(posedge clk_i);
    bus(1'b0, IDX_CTRL, 8'h00, rd);
    check("split high flag", {7'h0, rd[7]}, 8'h01);
    check("split high irq", {7'h0, irq_o}, 8'h01);
    wr(IDX_CTRL, 8'h00);
    // leftover status would spoil the capture status check
    wr(IDX_IRQST, 8'h07);
    wr(IDX_CLKSEL, 8'h00);
    $display("test split done");
    // divided sources, the last one in suspend
    for (int i = 0; i < 4; i++) begin
      suspend_i <= (i == 3);
      wr(IDX_CNTL, 8'h00);
      wr(IDX_CTRL, {6'h01, xs[i]});
      pulses(16);
      repeat (10) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      rdchk("source count", IDX_CNTL, ex[i]);
    end
    suspend_i <= 1'b0;
    wr(IDX_CNTL, 8'h00);
    wr(IDX_CTRL, 8'h04);
    repeat (240) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    bus(1'b0, IDX_CNTL, 8'h00, rd);
    check("sys div 12", {7'h0, rd >= 8'd19 && rd <= 8'd21}, 8'h01);
    $display("test sources done");
    // capture with split kept off
    wr(IDX_CNTL, 8'h34);
    wr(IDX_CNTH, 8'h12);
    wr(IDX_IRQMSK, 8'h04);
    wr(IDX_CTRL, 8'h10);
    lfo_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    lfo_i <= 1'b0;
    wait_irq(50);
    rdchk("capture low", IDX_RLL, 8'h34);
    rdchk("capture high", IDX_RLH, 8'h12);
    rdchk("capture ctrl", IDX_CTRL, 8'h90);
    rdchk("capture status", IDX_IRQST, 8'h04);
    $display("test capture done");
    // reset in mid run, with the capture interrupt still pending
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check("irq after mid reset", {7'h0, irq_o}, 8'h00);
    rdchk("ctrl after mid reset", IDX_CTRL, 8'h00);
    rdchk("reload after mid reset", IDX_RLH, 8'h00);
    $display("test reset done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
